// >>> rtl/dbu_receiver_top.v
// Purpose: receiver and bit-rate generator of the debug serial unit, APB slave
// Assumes: single clock ref_clk at 200 MHz, synchronous active-high rst
// Notes:   no transmitter; the transmit request output stays low
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "dbu_defines.vh"

// Operation
// [R1] bit-rate clock is master clock over sixteen times the divisor
// [R2] divisor zero stops the bit-rate clock and the serial function
// [R3] divisor is sixteen bits wide, one up to 65535 sixteenths
// [R4] receiver is disabled after reset until enabled by software
// [R5] enable command starts the hunt for a start bit
// [R6] disable stops at once when hunting, else after the stop bit
// [R7] receiver reset aborts reception, drops the character, disables
// [R8] start bit needs more than seven low sampling ticks
// [R9] first data sample twenty-four ticks after the falling edge
// [R10] each later sample sixteen ticks after the previous one
// [R11] asynchronous only, eight data bits, optional parity
// [R12] receiver independent, shared bit-rate generator, no timeout
// [R13] complete character goes to holding register, ready flag set
// [R14] reading the holding register, by software or transfer channel, clears ready
// [R15] new character while ready still set sets overrun
// [R16] overrun stays set until status clear command
// [R17] request signals for receive and transmit transfer channels; here the transmit request is tied low
// [R18] debug channel full indications readable and able to interrupt
// [R19] software bit forces the emulator test reset active
// [R20] parity checked per mode, error flag set with ready
// [R21] stop bit read low sets framing error with ready
// [R22] receive line passes a two-stage synchroniser first
// [R23] partner sends start, eight data bits LSB first, parity, stop
module dbu_receiver_top (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        serial_rx_line,
    input  wire        debug_channel_read_full,
    input  wire        debug_channel_write_full,
    input  wire        rx_dma_ack,
    output reg         rx_dma_req,
    output reg  [7:0]  rx_dma_data,
    output reg         tx_dma_req,
    output reg         debug_comm_irq,
    output reg         test_reset_force
);
    // one-hot receiver states
    localparam [5:0] ST_OFF    = 6'h01;
    localparam [5:0] ST_HUNT   = 6'h02;
    localparam [5:0] ST_START  = 6'h04;
    localparam [5:0] ST_DATA   = 6'h08;
    localparam [5:0] ST_PARITY = 6'h10;
    localparam [5:0] ST_STOP   = 6'h20;

    reg  [5:0]  state_reg;
    reg  [5:0]  state_next;
    reg  [4:0]  tick_cnt_reg;
    reg  [4:0]  tick_cnt_next;
    reg  [2:0]  bit_cnt_reg;
    reg  [2:0]  bit_cnt_next;
    reg  [7:0]  shift_reg;
    reg  [7:0]  shift_next;
    reg         parity_bad_reg;
    reg         parity_bad_next;
    reg         stop_pending_reg;
    reg         stop_pending_next;
    reg  [15:0] bit_rate_divisor_reg;
    reg  [2:0]  parity_mode_field;
    reg  [7:0]  rx_holding_register;
    reg         rx_ready_flag;
    reg         overrun_flag;
    reg         framing_error_flag;
    reg         parity_error_flag;
    reg         force_test_reset_bit;

    wire [2:0]  sync_q;
    wire        rx_line;
    wire        read_full_sync;
    wire        write_full_sync;
    wire        sample_tick;
    wire        bus_setup;
    wire        bus_access;
    wire        bus_write;
    wire        bus_read;
    wire        cmd_write;
    wire        cmd_rx_reset;
    wire        cmd_rx_enable;
    wire        cmd_rx_disable;
    wire        cmd_status_clear;
    wire        hold_read;
    wire        addr_known;
    wire        char_done;
    wire        expected_parity;
    wire        parity_enabled;
    wire        rx_enabled;
    reg  [31:0] read_mux;

    // pins and emulator status come from outside this clock domain
    dbu_sync2 #(
        .W (3)
    ) u_sync (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .async_in   ({debug_channel_write_full, debug_channel_read_full, serial_rx_line}),
        .idle_value (3'h1),
        .sync_out   (sync_q)
    ); // [R22]

    assign rx_line         = sync_q[0] | (state_reg == ST_OFF); // [R22]
    assign read_full_sync  = sync_q[1];
    assign write_full_sync = sync_q[2];

    // the generator serves only the receiver; there is no transmitter to share it
    dbu_baud_gen u_baud (
        .ref_clk       (ref_clk),
        .rst           (rst),
        .clock_divisor (bit_rate_divisor_reg),
        .sample_tick   (sample_tick)
    ); // [R12]

    // APB: setup cycle loads the answer, access cycle completes with no wait
    assign bus_setup  = psel & ~penable;
    assign bus_access = psel & penable & pready;
    assign bus_write  = bus_access & pwrite;
    assign bus_read   = bus_access & ~pwrite;
    assign addr_known = (paddr == `DBU_OFS_COMMAND) | (paddr == `DBU_OFS_FORMAT) |
                        (paddr == `DBU_OFS_FLAG) | (paddr == `DBU_OFS_RX_HOLD) |
                        (paddr == `DBU_OFS_DIVISOR) | (paddr == `DBU_OFS_TEST_RESET);

    // command strobes are one-cycle pulses decoded from the write
    assign cmd_write        = bus_write & (paddr == `DBU_OFS_COMMAND);
    assign cmd_rx_reset     = cmd_write & pwdata[`DBU_CMD_RX_RESET];
    assign cmd_rx_enable    = cmd_write & pwdata[`DBU_CMD_RX_ENABLE];
    assign cmd_rx_disable   = cmd_write & pwdata[`DBU_CMD_RX_DISABLE];
    assign cmd_status_clear = cmd_write & pwdata[`DBU_CMD_STATUS_CLEAR];
    assign hold_read        = (bus_read & (paddr == `DBU_OFS_RX_HOLD)) | rx_dma_ack; // [R14]

    // parity expected for the current mode over the data bits
    assign parity_enabled  = ~parity_mode_field[`DBU_PARITY_NONE_BIT];
    assign expected_parity = (parity_mode_field == `DBU_PARITY_EVEN)  ? ^shift_reg :
                             (parity_mode_field == `DBU_PARITY_ODD)   ? ~(^shift_reg) :
                             (parity_mode_field == `DBU_PARITY_SPACE) ? 1'b0 : 1'b1; // [R20]

    assign char_done  = (state_reg == ST_STOP) & sample_tick & (tick_cnt_reg == `DBU_FIRST_SAMPLE);
    assign rx_enabled = (state_reg != ST_OFF) & ~stop_pending_reg;

    // readback, reserved bits zero
    always @* begin
        read_mux = `DBU_RST_WORD;
        case (paddr)
            `DBU_OFS_FORMAT: begin
                read_mux[`DBU_PARITY_HI:`DBU_PARITY_LO] = parity_mode_field;
            end
            `DBU_OFS_FLAG: begin
                read_mux[`DBU_FLG_RX_READY]   = rx_ready_flag;
                read_mux[`DBU_FLG_OVERRUN]    = overrun_flag;
                read_mux[`DBU_FLG_FRAMING]    = framing_error_flag;
                read_mux[`DBU_FLG_PARITY]     = parity_error_flag;
                read_mux[`DBU_FLG_RX_ENABLED] = rx_enabled;
                read_mux[`DBU_FLG_WRITE_FULL] = write_full_sync; // [R18]
                read_mux[`DBU_FLG_READ_FULL]  = read_full_sync; // [R18]
            end
            `DBU_OFS_RX_HOLD: begin
                read_mux[7:0] = rx_holding_register;
            end
            `DBU_OFS_DIVISOR: begin
                read_mux[15:0] = bit_rate_divisor_reg;
            end
            `DBU_OFS_TEST_RESET: begin
                read_mux[0] = force_test_reset_bit;
            end
            default: begin
                read_mux = `DBU_RST_WORD;
            end
        endcase
    end

    // bus answer registers
    always @(posedge ref_clk) begin
        if (rst) begin
            prdata  <= `DBU_RST_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (bus_setup) begin
            prdata  <= pwrite ? `DBU_RST_WORD : read_mux;
            pready  <= 1'b1;
            pslverr <= ~addr_known;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // configuration registers written by software
    always @(posedge ref_clk) begin
        if (rst) begin
            bit_rate_divisor_reg <= `DBU_RST_DIVISOR;
            parity_mode_field    <= `DBU_RST_PARITY;
            force_test_reset_bit <= 1'b0;
        end else if (bus_write) begin
            if (paddr == `DBU_OFS_DIVISOR) begin
                bit_rate_divisor_reg <= pwdata[15:0]; // [R3]
            end
            if (paddr == `DBU_OFS_FORMAT) begin
                parity_mode_field <= pwdata[`DBU_PARITY_HI:`DBU_PARITY_LO]; // [R11]
            end
            if (paddr == `DBU_OFS_TEST_RESET) begin
                force_test_reset_bit <= pwdata[0]; // [R19]
            end
        end
    end

    // receiver sequencing; ticks only advance it, so a zero divisor freezes it
    always @* begin
        state_next        = state_reg;
        tick_cnt_next     = tick_cnt_reg;
        bit_cnt_next      = bit_cnt_reg;
        shift_next        = shift_reg;
        parity_bad_next   = parity_bad_reg;
        stop_pending_next = stop_pending_reg;
        case (state_reg)
            ST_OFF: begin
                stop_pending_next = 1'b0;
            end
            ST_HUNT: begin
                if (sample_tick & ~rx_line & (bit_rate_divisor_reg != `DBU_RST_DIVISOR)) begin // [R2]
                    state_next    = ST_START;
                    tick_cnt_next = 5'h01;
                end
            end
            ST_START: begin
                if (sample_tick) begin
                    if (rx_line) begin
                        state_next = ST_HUNT; // [R8]
                    end else if (tick_cnt_reg == `DBU_START_LOW_LAST) begin
                        state_next    = ST_DATA; // [R8]
                        tick_cnt_next = tick_cnt_reg + 5'h01;
                        bit_cnt_next  = 3'h0;
                    end else begin
                        tick_cnt_next = tick_cnt_reg + 5'h01;
                    end
                end
            end
            ST_DATA, ST_PARITY, ST_STOP: begin
                if (sample_tick) begin
                    if (tick_cnt_reg == `DBU_FIRST_SAMPLE) begin // [R9]
                        tick_cnt_next = `DBU_SAMPLE_RELOAD; // [R10]
                        if (state_reg == ST_DATA) begin
                            shift_next   = {rx_line, shift_reg[7:1]}; // [R11]
                            bit_cnt_next = bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == `DBU_DATA_LAST) begin
                                state_next = parity_enabled ? ST_PARITY : ST_STOP;
                            end
                        end else if (state_reg == ST_PARITY) begin
                            parity_bad_next = rx_line ^ expected_parity; // [R20]
                            state_next      = ST_STOP;
                        end else begin
                            state_next = stop_pending_reg ? ST_OFF : ST_HUNT; // [R6]
                        end
                    end else begin
                        tick_cnt_next = tick_cnt_reg + 5'h01;
                    end
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (state_reg == ST_HUNT && state_next == ST_HUNT) begin
            parity_bad_next = 1'b0;
        end
        // commands override the sequencing; reset beats disable beats enable
        if (cmd_rx_reset) begin
            state_next        = ST_OFF; // [R7]
            stop_pending_next = 1'b0;
        end else if (cmd_rx_disable) begin
            if ((state_reg == ST_HUNT) || (state_reg == ST_START)) begin
                state_next = ST_OFF; // [R6]
            end else if (state_reg != ST_OFF) begin
                stop_pending_next = 1'b1; // [R6]
            end
        end else if (cmd_rx_enable) begin
            stop_pending_next = 1'b0;
            if (state_reg == ST_OFF) begin
                state_next = ST_HUNT; // [R5]
            end
        end
    end

    // receiver state registers, disabled out of reset
    always @(posedge ref_clk) begin
        if (rst) begin
            state_reg        <= ST_OFF; // [R4]
            tick_cnt_reg     <= 5'h00;
            bit_cnt_reg      <= 3'h0;
            shift_reg        <= `DBU_RST_BYTE;
            parity_bad_reg   <= 1'b0;
            stop_pending_reg <= 1'b0;
        end else begin
            state_reg        <= state_next;
            tick_cnt_reg     <= tick_cnt_next;
            bit_cnt_reg      <= bit_cnt_next;
            shift_reg        <= shift_next;
            parity_bad_reg   <= parity_bad_next;
            stop_pending_reg <= stop_pending_next;
        end
    end

    // holding register and status flags; a set in the same cycle wins over a clear
    always @(posedge ref_clk) begin
        if (rst) begin
            rx_holding_register <= `DBU_RST_BYTE;
            rx_ready_flag       <= 1'b0;
            overrun_flag        <= 1'b0;
            framing_error_flag  <= 1'b0;
            parity_error_flag   <= 1'b0;
        end else begin
            // a reset command in the stop cycle discards the character
            if (char_done & ~cmd_rx_reset) begin
                rx_holding_register <= shift_reg; // [R13]
                rx_ready_flag       <= 1'b1; // [R13]
            end else if (hold_read) begin
                rx_ready_flag <= 1'b0; // [R14]
            end
            if (char_done & ~cmd_rx_reset & rx_ready_flag & ~hold_read) begin
                overrun_flag <= 1'b1; // [R15]
            end else if (cmd_status_clear) begin
                overrun_flag <= 1'b0; // [R16]
            end
            if (char_done & ~cmd_rx_reset & ~rx_line) begin
                framing_error_flag <= 1'b1; // [R21]
            end else if (cmd_status_clear) begin
                framing_error_flag <= 1'b0; // [R21]
            end
            if (char_done & ~cmd_rx_reset & parity_bad_reg) begin
                parity_error_flag <= 1'b1; // [R20]
            end else if (cmd_status_clear) begin
                parity_error_flag <= 1'b0; // [R20]
            end
        end
    end

    // side outputs, all registered
    always @(posedge ref_clk) begin
        if (rst) begin
            rx_dma_req       <= 1'b0;
            rx_dma_data      <= `DBU_RST_BYTE;
            tx_dma_req       <= 1'b0;
            debug_comm_irq   <= 1'b0;
            test_reset_force <= 1'b0;
        end else begin
            // request takes the ready flag's next value; the channel pulses ack once
            rx_dma_req       <= (rx_ready_flag & ~hold_read) | (char_done & ~cmd_rx_reset); // [R17]
            rx_dma_data      <= (char_done & ~cmd_rx_reset) ? shift_reg : rx_holding_register;
            tx_dma_req       <= 1'b0; // [R17]
            debug_comm_irq   <= read_full_sync | write_full_sync; // [R18]
            test_reset_force <= force_test_reset_bit; // [R19]
        end
    end
endmodule

// >>> rtl/dbu_defines.vh
// Purpose: shared constants of the debug serial unit receiver
// Assumes: 32-bit APB data, byte addresses on paddr
// Notes:   definitions only, no logic
`ifndef DBU_DEFINES_VH
`define DBU_DEFINES_VH

// register byte offsets
`define DBU_OFS_COMMAND      8'h00
`define DBU_OFS_FORMAT       8'h04
`define DBU_OFS_FLAG         8'h14
`define DBU_OFS_RX_HOLD      8'h18
`define DBU_OFS_DIVISOR      8'h20
`define DBU_OFS_TEST_RESET   8'h40

// command register bit positions
`define DBU_CMD_RX_RESET     2
`define DBU_CMD_RX_ENABLE    4
`define DBU_CMD_RX_DISABLE   5
`define DBU_CMD_STATUS_CLEAR 8

// format register parity field and codes
`define DBU_PARITY_HI        11
`define DBU_PARITY_LO        9
`define DBU_PARITY_EVEN      3'h0
`define DBU_PARITY_ODD       3'h1
`define DBU_PARITY_SPACE     3'h2
`define DBU_PARITY_MARK      3'h3
`define DBU_PARITY_NONE_BIT  2

// flag register bit positions
`define DBU_FLG_RX_READY     0
`define DBU_FLG_OVERRUN      5
`define DBU_FLG_FRAMING      6
`define DBU_FLG_PARITY       7
`define DBU_FLG_RX_ENABLED   8
`define DBU_FLG_WRITE_FULL   30
`define DBU_FLG_READ_FULL    31

// reset values
`define DBU_RST_DIVISOR      16'h0000
`define DBU_RST_PARITY       3'h4
`define DBU_RST_WORD         32'h0000_0000
`define DBU_RST_BYTE         8'h00

// sampling clock counts, 16 samples per bit
`define DBU_START_LOW_LAST   5'h07
`define DBU_FIRST_SAMPLE     5'h18
`define DBU_BIT_TICKS        5'h10
`define DBU_SAMPLE_RELOAD    5'h09
`define DBU_DATA_LAST        3'h7

`endif

// >>> rtl/dbu_sync2.v
// Purpose: two flip-flop synchroniser, one chain per bit
// Assumes: inputs come from pins or another clock domain
// Notes:   the first stage is read only by the second stage
`timescale 1ns/1ps
module dbu_sync2 #(
    parameter W = 3
) (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    input  wire [W-1:0] idle_value,
    output wire [W-1:0] sync_out
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_reg;
            reg stable_reg;
            // reset loads the idle level so no false edge follows reset
            always @(posedge ref_clk) begin
                if (rst) begin
                    meta_reg   <= idle_value[i];
                    stable_reg <= idle_value[i];
                end else begin
                    meta_reg   <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate
endmodule

// >>> rtl/dbu_baud_gen.v
// Purpose: bit-rate generator of the receiver only, one sampling tick per divisor period
// Assumes: divisor comes from a register on the same clock
// Notes:   a zero divisor stops the ticks entirely
`timescale 1ns/1ps
`include "dbu_defines.vh"
module dbu_baud_gen (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire [15:0] clock_divisor,
    output reg         sample_tick
);
    reg [15:0] div_cnt_reg;

    // sample tick at master_clock/divisor, bit clock is sixteen ticks
    always @(posedge ref_clk) begin
        if (rst) begin
            div_cnt_reg <= `DBU_RST_DIVISOR;
            sample_tick <= 1'b0;
        end else if (clock_divisor == `DBU_RST_DIVISOR) begin // [R2]
            div_cnt_reg <= `DBU_RST_DIVISOR;
            sample_tick <= 1'b0;
        end else if (div_cnt_reg >= clock_divisor - 16'h0001) begin // [R1]
            // >= compare lets a lowered divisor take effect at once
            div_cnt_reg <= `DBU_RST_DIVISOR;
            sample_tick <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
            sample_tick <= 1'b0;
        end
    end
endmodule

// >>> verification/dbu_rx_checker_asserts.sv
// Purpose: port-level checks of the debug serial receiver
// Assumes: one clock, synchronous active-high rst
// Notes:   ready is seen through rx_dma_req
`timescale 1ns/1ps
`include "dbu_defines.vh"
module dbu_rx_checker (
    input wire        ref_clk,
    input wire        rst,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        debug_channel_read_full,
    input wire        debug_channel_write_full,
    input wire        rx_dma_ack,
    input wire        rx_dma_req,
    input wire [7:0]  rx_dma_data,
    input wire        tx_dma_req,
    input wire        debug_comm_irq,
    input wire        test_reset_force
);
    reg  en_seen_reg;
    wire acc = psel && penable && pready;
    wire src = debug_channel_read_full || debug_channel_write_full;
    // sticky: a later disable must not make an early char illegal
    always @(posedge ref_clk) begin
        if (rst)
            en_seen_reg <= 1'b0;
        else if (acc && pwrite && paddr == `DBU_OFS_COMMAND && pwdata[`DBU_CMD_RX_ENABLE])
            en_seen_reg <= 1'b1;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_hold_read_clr; acc && !pwrite && paddr == `DBU_OFS_RX_HOLD |-> ##2 !rx_dma_req; endproperty
    a_hold_read_clr: assert property (p_hold_read_clr) else $error("ready kept after holding read");
    property p_ack_clr; rx_dma_ack |-> ##2 !rx_dma_req; endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ready kept after channel ack");
    property p_no_tx_req; !tx_dma_req; endproperty
    a_no_tx_req: assert property (p_no_tx_req) else $error("transmit request raised");
    property p_irq_on; src [*5] |=> debug_comm_irq; endproperty
    a_irq_on: assert property (p_irq_on) else $error("channel irq missing");
    property p_irq_off; !src [*5] |=> !debug_comm_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("channel irq without source");
    property p_force; acc && pwrite && paddr == `DBU_OFS_TEST_RESET && pwdata[0] |-> ##[1:3] test_reset_force;
    endproperty
    a_force: assert property (p_force) else $error("test reset not forced");
    property p_off_after_rst; !en_seen_reg |-> !rx_dma_req; endproperty
    a_off_after_rst: assert property (p_off_after_rst) else $error("char before enable");
    property p_hold_data; psel && penable && !pwrite && paddr == `DBU_OFS_RX_HOLD
        |-> prdata == {24'h00_0000, $past(rx_dma_data)}; endproperty
    a_hold_data: assert property (p_hold_data) else $error("holding read data wrong");
    c_char: cover property ($rose(rx_dma_req));
    c_err: cover property (pready && pslverr);
    c_force: cover property ($rose(test_reset_force));
endmodule

// >>> verification/dbu_serial_host.sv
// Purpose: far-end serial transmitter model
// Assumes: bit period given in ref_clk cycles
// Notes:   line idles high as a stopped transmitter does
`timescale 1ns/1ps
module dbu_serial_host (
    input wire ref_clk,
    output reg serial_rx_line
);
    initial serial_rx_line = 1'b1;
    // start, eight bits lsb first, optional parity, stop; pb < 0 means no parity
    task automatic send(input logic [7:0] d, input int pb, input logic stp, input int per);
        int i;
        @(posedge ref_clk) serial_rx_line <= 1'b0;
        repeat (per) @(posedge ref_clk);
        for (i = 0; i < 9; i++) begin
            if (i < 8 || pb >= 0) begin
                serial_rx_line <= (i < 8) ? d[i] : pb[0];
                repeat (per) @(posedge ref_clk);
            end
        end
        serial_rx_line <= stp;
        // a bad stop is cut short so the tail is not taken as a new start
        repeat (stp ? per : per * 12 / 16) @(posedge ref_clk);
        serial_rx_line <= 1'b1;
        repeat (per) @(posedge ref_clk);
    endtask
    // lone low pulse of n cycles
    task automatic pulse(input int n);
        @(posedge ref_clk) serial_rx_line <= 1'b0;
        repeat (n) @(posedge ref_clk);
        serial_rx_line <= 1'b1;
    endtask
endmodule

// >>> verification/tb_top.sv
// Purpose: directed test of the debug serial receiver
// Assumes: APB answers after one access cycle, divisor 0, 1 or 3
// Notes:   expected flags come from the bit map
`timescale 1ns/1ps
`include "dbu_defines.vh"
module tb_top;
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic        er, rdf = 0, wrf = 0, rx_dma_ack = 0;
    wire  [31:0] prdata;
    wire  [7:0]  rx_dma_data;
    wire         pready, pslverr, line, rx_dma_req, tx_dma_req, irq, trf;
    int          n_mismatch = 0, num_checks = 0, cyc = 0, m;
    always #2.5 ref_clk = ~ref_clk;
    dbu_serial_host host (.ref_clk(ref_clk), .serial_rx_line(line));
    dbu_receiver_top uut (.*, .serial_rx_line(line), .debug_channel_read_full(rdf),
        .debug_channel_write_full(wrf), .debug_comm_irq(irq), .test_reset_force(trf));
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk) penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e); apb(0, a, 0); chk(rd, e); endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
    task automatic rx(input logic [7:0] d, input int pb, input logic s, input int per);
        host.send(d, pb, s, per); repeat (4) @(posedge ref_clk);
    endtask
    function automatic int par(input logic [7:0] d, input int md);
        return md == 0 ? ^d : md == 1 ? ~^d : md == 2 ? 0 : 1;
    endfunction
    // run ceiling well above the longest sequence
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin n_mismatch++; report_and_stop(); end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        rdc(`DBU_OFS_FORMAT, 32'h0000_0800);
        rdc(`DBU_OFS_DIVISOR, 32'h0000_0000);
        rdc(`DBU_OFS_FLAG, 32'h0000_0000);
        rdc(`DBU_OFS_TEST_RESET, 32'h0000_0000);
        apb(0, 8'h3c, 0); chk(er, 1);
        wr(`DBU_OFS_COMMAND, 32'h0000_0010); rx(8'h3c, -1, 1, 16);
        rdc(`DBU_OFS_FLAG, 32'h0000_0100);
        wr(`DBU_OFS_DIVISOR, 32'h0000_0001); rx(8'ha5, -1, 1, 16);
        rdc(`DBU_OFS_FLAG, 32'h0000_0101);
        chk({rx_dma_req, rx_dma_data}, 9'h1a5);
        rdc(`DBU_OFS_RX_HOLD, 32'h0000_00a5);
        rdc(`DBU_OFS_FLAG, 32'h0000_0100);
        rx(8'h11, -1, 1, 16); rx(8'h22, -1, 1, 16);
        rdc(`DBU_OFS_FLAG, 32'h0000_0121);
        rdc(`DBU_OFS_RX_HOLD, 32'h0000_0022);
        rdc(`DBU_OFS_FLAG, 32'h0000_0120);
        wr(`DBU_OFS_COMMAND, 32'h0000_0100);
        rdc(`DBU_OFS_FLAG, 32'h0000_0100);
        rx(8'h5a, -1, 0, 16);
        rdc(`DBU_OFS_FLAG, 32'h0000_0141);
        @(posedge ref_clk) rx_dma_ack <= 1;
        @(posedge ref_clk) rx_dma_ack <= 0;
        rdc(`DBU_OFS_FLAG, 32'h0000_0140);
        wr(`DBU_OFS_COMMAND, 32'h0000_0100);
        for (m = 0; m < 4; m++) begin
            wr(`DBU_OFS_FORMAT, m << 9); rx(8'hc3 + m, par(8'hc3 + m, m), 1, 16);
            rdc(`DBU_OFS_FLAG, 32'h0000_0101);
            rdc(`DBU_OFS_RX_HOLD, 8'hc3 + m);
        end
        wr(`DBU_OFS_FORMAT, 32'h0000_0000); rx(8'h07, 0, 1, 16);
        rdc(`DBU_OFS_FLAG, 32'h0000_0181);
        rdc(`DBU_OFS_RX_HOLD, 32'h0000_0007); wr(`DBU_OFS_COMMAND, 32'h0000_0100);
        wr(`DBU_OFS_FORMAT, 32'h0000_0800); host.pulse(7); repeat (40) @(posedge ref_clk);
        rdc(`DBU_OFS_FLAG, 32'h0000_0100);
        host.pulse(10); repeat (200) @(posedge ref_clk);
        rdc(`DBU_OFS_RX_HOLD, 32'h0000_00ff);
        wr(`DBU_OFS_DIVISOR, 32'h0000_0003); rx(8'h96, -1, 1, 48);
        rdc(`DBU_OFS_RX_HOLD, 32'h0000_0096);
        wr(`DBU_OFS_COMMAND, 32'h0000_0020);
        rdc(`DBU_OFS_FLAG, 32'h0000_0000);
        wr(`DBU_OFS_COMMAND, 32'h0000_0010);
        fork rx(8'h3e, -1, 1, 48); begin repeat (150) @(posedge ref_clk); wr(`DBU_OFS_COMMAND, 32'h0000_0020); end join
        rdc(`DBU_OFS_FLAG, 32'h0000_0001);
        rdc(`DBU_OFS_RX_HOLD, 32'h0000_003e);
        wr(`DBU_OFS_COMMAND, 32'h0000_0010);
        fork rx(8'h77, -1, 1, 48); begin repeat (150) @(posedge ref_clk); wr(`DBU_OFS_COMMAND, 32'h0000_0004); end join
        rdc(`DBU_OFS_FLAG, 32'h0000_0000);
        wr(`DBU_OFS_TEST_RESET, 32'h0000_0001); rdc(`DBU_OFS_TEST_RESET, 32'h0000_0001);
        chk(trf, 1);
        rdf <= 1; repeat (6) @(posedge ref_clk);
        rdc(`DBU_OFS_FLAG, 32'h8000_0000); chk(irq, 1);
        rdf <= 0; wrf <= 1; repeat (6) @(posedge ref_clk);
        rdc(`DBU_OFS_FLAG, 32'h4000_0000); chk(tx_dma_req, 0);
        report_and_stop();
    end
endmodule
bind dbu_receiver_top dbu_rx_checker u_chk (.*);
